// >>> src/boost_seq_pkg.sv
// shared constants and carrier types for the boost mode sequencer
package boost_seq_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned LOW_CHARGE_US   = 500;
    localparam int unsigned HIGH_CHARGE_US  = 1000;
    localparam int unsigned SW_SOFT_US      = 100;
    localparam int unsigned RESTART_MS      = 20;
    localparam int unsigned OVERLOAD_MS     = 2;
    localparam int unsigned BYPASS_QUAL_NS  = 5000;
    localparam int unsigned PWM_KHZ         = 2500;

    localparam int unsigned LOW_CHARGE_CYC  = LOW_CHARGE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HIGH_CHARGE_CYC = HIGH_CHARGE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SW_SOFT_CYC     = SW_SOFT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RESTART_CYC     = RESTART_MS * (CLK_HZ / 1_000);
    localparam int unsigned OVERLOAD_CYC    = OVERLOAD_MS * (CLK_HZ / 1_000);
    localparam int unsigned BYPASS_QUAL_CYC = (BYPASS_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PWM_PERIOD_CYC  = (CLK_HZ / 1000) / PWM_KHZ;

    localparam int unsigned TIMER_W         = 24;

    localparam logic [2:0]  SYNC_RESET      = 3'h0;

    // analog comparator flags
    typedef struct packed {
        logic uvlo_ok;
        logic out_above_in_minus_300;
        logic out_at_in;
        logic out_at_target;
        logic in_above_target_minus_250;
        logic in_below_target_minus_350;
        logic in_above_out_plus_350;
        logic out_below_in_minus_450;
        logic peak_current_limit;
        logic over_temperature_shutdown;
        logic light_load;
    } analog_flags_s;

    // power stage controls
    typedef struct packed {
        logic low_charge_current;
        logic high_charge_current;
        logic switching;
        logic pfm;
        logic quarter_limit;
        logic output_pass_switch;
        logic forced_bypass;
        logic auto_bypass;
        logic pwm_gate;
        logic high_pfm_target;
        logic fault;
    } stage_ctrl_s;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_LOW_CHARGE,
        ST_HIGH_CHARGE,
        ST_SW_SOFT,
        ST_BOOST,
        ST_AUTO_BYPASS,
        ST_FORCED_BYPASS,
        ST_FAULT
    } seq_state_e;

endpackage

// >>> src/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // raw and filtered level
    input  wire logic [W-1:0] raw_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= raw_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // change accepted once stages two and three agree
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    level_out[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/pwm_clock.sv
// fixed-frequency pwm switching tick
`timescale 1ns/100ps
`default_nettype none
module pwm_clock (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // run control and gate
    input  wire logic run_in,
    output logic      gate_out
);
    logic [7:0] count;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count    <= 8'h00;
            gate_out <= 1'b0;
        end else if (!run_in) begin
            count    <= 8'h00;
            gate_out <= 1'b0;
        end else begin
            if (count == 8'(boost_seq_pkg::PWM_PERIOD_CYC - 1)) begin
                count <= 8'h00;
            end else begin
                count <= count + 8'h01;
            end
            gate_out <= (count < 8'(boost_seq_pkg::PWM_PERIOD_CYC / 2));
        end
    end
endmodule
`default_nettype wire

// >>> src/boost_mode_sequencer.sv
// startup, mode and fault sequencer for a battery-fed boost regulator
// Notes on behaviour
// - start boosting or forced bypass, both via two-stage linear soft start
// - low charge current up to 500 us, then high current up to 1 ms
// - boost start: output at input minus 300 mV ends charging, go switching soft start
// - threshold missed after high charge stage: stop charging, fault, restart after 20 ms
// - forced start: output reaching input enters forced bypass
// - switching soft start in pfm at quarter limit until target or 100 us
// - enable low stops boosting, output discharges into load
// - pwm boosting switches at fixed 2.5 MHz
// - light load below about 80 mA selects pfm
// - pfm regulates to a higher average target than pwm
// - input above target minus 250 mV for 5 us enters auto bypass
// - input 350 mV below target leaves auto bypass, resumes boosting
// - enable and select high give forced bypass; controller drives select
// - output pulled 300 mV below input faults
// - soft start faults after 1.5 ms charging or 100 us switching; restart 20 ms
// - peak limit held 2 ms faults; 300 mV drop faults at once
// - fault opens pass switch fully, restart every 20 ms
// - auto bypass: input above output by 350 mV faults, retry every 20 ms
// - forced bypass: output below input minus 450 mV faults and retries
// - over temperature disables switching until hysteresis recovered
// - lockout release with enable starts soft start; lockout sets output high impedance
`timescale 1ns/100ps
`default_nettype none
module boost_mode_sequencer (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // pins
    input  wire logic                         enable_in,
    input  wire logic                         pass_through_select_in,
    // analog comparator flags
    input  wire boost_seq_pkg::analog_flags_s flags_in,
    // power stage controls and sequencer state
    output boost_seq_pkg::stage_ctrl_s        ctrl_out,
    output boost_seq_pkg::seq_state_e         state_out
);
    localparam int unsigned FW = $bits(boost_seq_pkg::analog_flags_s);

    boost_seq_pkg::analog_flags_s flags;
    boost_seq_pkg::seq_state_e    state;
    boost_seq_pkg::seq_state_e    next_state;
    boost_seq_pkg::stage_ctrl_s   next_ctrl;
    logic [1:0]                   pins;
    logic                         enable;
    logic                         select;
    logic                         start_forced;
    logic [boost_seq_pkg::TIMER_W-1:0] timer;
    logic [boost_seq_pkg::TIMER_W-1:0] overload;
    logic [boost_seq_pkg::TIMER_W-1:0] bypass_qual;
    logic                         timer_clear;
    logic                         pwm_gate;

    function automatic logic expired(input logic [boost_seq_pkg::TIMER_W-1:0] t,
                                     input int unsigned lim);
        expired = (t >= boost_seq_pkg::TIMER_W'(lim - 1));
    endfunction

    // comparator and pin synchronisers
    pin_sync #(.W(FW)) u_flag_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .raw_in    (flags_in),
        .level_out (flags)
    );

    pin_sync #(.W(2)) u_pin_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .raw_in    ({enable_in, pass_through_select_in}),
        .level_out (pins)
    );

    assign enable = pins[1];
    assign select = pins[0];

    // pwm switching tick
    pwm_clock u_pwm (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .run_in   (state == boost_seq_pkg::ST_BOOST && !flags.light_load),
        .gate_out (pwm_gate)
    );

    // state timer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            timer <= '0;
        end else if (timer_clear) begin
            timer <= '0;
        end else if (timer != '1) begin
            timer <= timer + 1'b1;
        end
    end

    // overload hold counter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            overload <= '0;
        end else if (state == boost_seq_pkg::ST_BOOST && flags.peak_current_limit) begin
            if (overload != '1) begin
                overload <= overload + 1'b1;
            end
        end else begin
            overload <= '0;
        end
    end

    // bypass qualification counter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bypass_qual <= '0;
        end else if (state == boost_seq_pkg::ST_BOOST && flags.in_above_target_minus_250) begin
            if (bypass_qual != '1) begin
                bypass_qual <= bypass_qual + 1'b1;
            end
        end else begin
            bypass_qual <= '0;
        end
    end

    // startup path latched when leaving off
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_forced <= 1'b0;
        end else if (state == boost_seq_pkg::ST_OFF || state == boost_seq_pkg::ST_FAULT) begin
            start_forced <= select;
        end
    end

    // next state
    always_comb begin
        next_state  = state;
        timer_clear = 1'b0;
        case (state)
            boost_seq_pkg::ST_OFF: begin
                if (enable && flags.uvlo_ok) begin
                    next_state = boost_seq_pkg::ST_LOW_CHARGE;
                end
            end
            boost_seq_pkg::ST_LOW_CHARGE: begin
                if (!start_forced && flags.out_above_in_minus_300) begin
                    next_state = boost_seq_pkg::ST_SW_SOFT;
                end else if (start_forced && flags.out_at_in) begin
                    next_state = boost_seq_pkg::ST_FORCED_BYPASS;
                end else if (expired(timer, boost_seq_pkg::LOW_CHARGE_CYC)) begin
                    next_state = boost_seq_pkg::ST_HIGH_CHARGE;
                end
            end
            boost_seq_pkg::ST_HIGH_CHARGE: begin
                if (!start_forced && flags.out_above_in_minus_300) begin
                    next_state = boost_seq_pkg::ST_SW_SOFT;
                end else if (start_forced && flags.out_at_in) begin
                    next_state = boost_seq_pkg::ST_FORCED_BYPASS;
                end else if (expired(timer, boost_seq_pkg::HIGH_CHARGE_CYC)) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end
            end
            boost_seq_pkg::ST_SW_SOFT: begin
                if (!flags.out_above_in_minus_300) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end else if (flags.out_at_target) begin
                    next_state = boost_seq_pkg::ST_BOOST;
                end else if (expired(timer, boost_seq_pkg::SW_SOFT_CYC)) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end
            end
            boost_seq_pkg::ST_BOOST: begin
                if (!flags.out_above_in_minus_300) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end else if (overload >= boost_seq_pkg::TIMER_W'(boost_seq_pkg::OVERLOAD_CYC)) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end else if (bypass_qual >= boost_seq_pkg::TIMER_W'(boost_seq_pkg::BYPASS_QUAL_CYC)) begin
                    next_state = boost_seq_pkg::ST_AUTO_BYPASS;
                end
            end
            boost_seq_pkg::ST_AUTO_BYPASS: begin
                if (flags.in_above_out_plus_350) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end else if (flags.in_below_target_minus_350) begin
                    next_state = boost_seq_pkg::ST_BOOST;
                end
            end
            boost_seq_pkg::ST_FORCED_BYPASS: begin
                if (flags.out_below_in_minus_450) begin
                    next_state = boost_seq_pkg::ST_FAULT;
                end else if (!select) begin
                    next_state = boost_seq_pkg::ST_LOW_CHARGE;
                end
            end
            boost_seq_pkg::ST_FAULT: begin
                if (expired(timer, boost_seq_pkg::RESTART_CYC)) begin
                    next_state = boost_seq_pkg::ST_OFF;
                end
            end
            default: begin
                next_state = boost_seq_pkg::ST_OFF;
            end
        endcase
        // enable low overrides all but fault timing; lockout all but fault timing and the select move below
        if ((!enable || !flags.uvlo_ok) && state != boost_seq_pkg::ST_FAULT) begin
            next_state = boost_seq_pkg::ST_OFF;
        end
        // select raised while boosting moves to forced bypass
        if (enable && select && (state == boost_seq_pkg::ST_BOOST || state == boost_seq_pkg::ST_AUTO_BYPASS)) begin
            next_state = boost_seq_pkg::ST_FORCED_BYPASS;
        end
        if (next_state != state) begin
            timer_clear = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= boost_seq_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // output decode
    always_comb begin
        next_ctrl = '0;
        case (next_state)
            boost_seq_pkg::ST_LOW_CHARGE: begin
                next_ctrl.low_charge_current = 1'b1;
            end
            boost_seq_pkg::ST_HIGH_CHARGE: begin
                next_ctrl.high_charge_current = 1'b1;
            end
            boost_seq_pkg::ST_SW_SOFT: begin
                next_ctrl.switching     = 1'b1;
                next_ctrl.pfm           = 1'b1;
                next_ctrl.quarter_limit = 1'b1;
                next_ctrl.output_pass_switch = 1'b1;
            end
            boost_seq_pkg::ST_BOOST: begin
                next_ctrl.switching          = 1'b1;
                next_ctrl.pfm                = flags.light_load;
                next_ctrl.high_pfm_target    = flags.light_load;
                next_ctrl.pwm_gate           = pwm_gate && !flags.light_load;
                next_ctrl.output_pass_switch = 1'b1;
            end
            boost_seq_pkg::ST_AUTO_BYPASS: begin
                next_ctrl.auto_bypass        = 1'b1;
                next_ctrl.output_pass_switch = 1'b1;
            end
            boost_seq_pkg::ST_FORCED_BYPASS: begin
                next_ctrl.forced_bypass      = 1'b1;
                next_ctrl.output_pass_switch = 1'b1;
            end
            boost_seq_pkg::ST_FAULT: begin
                next_ctrl.fault = 1'b1;
            end
            default: begin
                next_ctrl = '0;
            end
        endcase
        if (flags.over_temperature_shutdown) begin
            next_ctrl.switching = 1'b0;
            next_ctrl.pwm_gate  = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_out  <= '0;
            state_out <= boost_seq_pkg::ST_OFF;
        end else begin
            ctrl_out  <= next_ctrl;
            state_out <= next_state;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/boost_mode_sequencer_checker.sv
// port-level assertion checker for the boost mode sequencer
`timescale 1ns/100ps
`default_nettype none
module boost_mode_sequencer_checker (
    // clock and reset
    input wire logic                         clk_in,
    input wire logic                         rst_in,
    // watched ports
    input wire logic                         enable_in,
    input wire logic                         pass_through_select_in,
    input wire boost_seq_pkg::analog_flags_s flags_in,
    input wire boost_seq_pkg::stage_ctrl_s   ctrl_out,
    input wire boost_seq_pkg::seq_state_e    state_out
);
    int unsigned               state_run;
    boost_seq_pkg::seq_state_e last_state;
    int unsigned               gate_run;
    logic                      last_gate;
    logic                      gate_armed;
    logic                      gate_clean;
    logic                      pwm_run;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    assign pwm_run = (state_out == boost_seq_pkg::ST_BOOST) && !ctrl_out.pfm && ctrl_out.switching;

    // cycles spent in the current state
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_run  <= 32'h0;
            last_state <= boost_seq_pkg::ST_OFF;
        end else begin
            state_run  <= (state_out != last_state) ? 32'h1 : state_run + 32'h1;
            last_state <= state_out;
        end
    end

    // pwm half period, valid only between two whole edges while pwm boosting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gate_run   <= 32'h0;
            last_gate  <= 1'b0;
            gate_armed <= 1'b0;
            gate_clean <= 1'b0;
        end else begin
            gate_run   <= (ctrl_out.pwm_gate != last_gate) ? 32'h1 : gate_run + 32'h1;
            gate_armed <= pwm_run && (gate_armed || (ctrl_out.pwm_gate != last_gate));
            gate_clean <= pwm_run && (gate_clean || (gate_armed && (ctrl_out.pwm_gate != last_gate)));
            last_gate  <= ctrl_out.pwm_gate;
        end
    end

    sequence fault_entry;
        $rose(state_out == boost_seq_pkg::ST_FAULT);
    endsequence
    sequence fault_hold;
        (state_out == boost_seq_pkg::ST_FAULT && ctrl_out.fault && !ctrl_out.output_pass_switch) [*8];
    endsequence
    sequence auto_entry;
        $rose(state_out == boost_seq_pkg::ST_AUTO_BYPASS);
    endsequence
    sequence auto_ctrl;
        $past(state_out) == boost_seq_pkg::ST_BOOST && ctrl_out.auto_bypass && ctrl_out.output_pass_switch;
    endsequence

    fault_sticks_a: assert property (fault_entry |-> fault_hold)
        else $error("fault state not held with pass switch open");
    fault_quiet_a: assert property (state_out == boost_seq_pkg::ST_FAULT |-> !ctrl_out.switching &&
        !ctrl_out.low_charge_current && !ctrl_out.high_charge_current)
        else $error("fault state still charging or switching");
    soft_quarter_a: assert property (state_out == boost_seq_pkg::ST_SW_SOFT |->
        ctrl_out.switching && ctrl_out.pfm && ctrl_out.quarter_limit)
        else $error("switching soft start controls wrong");
    boost_limit_a: assert property (state_out == boost_seq_pkg::ST_BOOST |-> !ctrl_out.quarter_limit &&
        !ctrl_out.low_charge_current && !ctrl_out.high_charge_current)
        else $error("boost with reduced limit or charging");
    charge_order_a: assert property ($rose(state_out == boost_seq_pkg::ST_HIGH_CHARGE) |->
        $past(state_out) == boost_seq_pkg::ST_LOW_CHARGE)
        else $error("high charge not entered from low charge");
    low_time_a: assert property (state_out == boost_seq_pkg::ST_LOW_CHARGE |->
        state_run <= boost_seq_pkg::LOW_CHARGE_CYC)
        else $error("low charge stage too long");
    soft_time_a: assert property (state_out == boost_seq_pkg::ST_SW_SOFT |->
        state_run <= boost_seq_pkg::SW_SOFT_CYC)
        else $error("switching soft start too long");
    pwm_period_a: assert property ((ctrl_out.pwm_gate != last_gate) && gate_clean && pwm_run |->
        gate_run == boost_seq_pkg::PWM_PERIOD_CYC / 2)
        else $error("pwm half period wrong");
    auto_enter_a: assert property (auto_entry |-> auto_ctrl and !ctrl_out.switching)
        else $error("auto bypass entry wrong");
    forced_ctrl_a: assert property (state_out == boost_seq_pkg::ST_FORCED_BYPASS |->
        ctrl_out.forced_bypass && ctrl_out.output_pass_switch && !ctrl_out.switching)
        else $error("forced bypass controls wrong");
    off_quiet_a: assert property (state_out == boost_seq_pkg::ST_OFF |-> !ctrl_out.switching &&
        !ctrl_out.output_pass_switch && !ctrl_out.low_charge_current && !ctrl_out.high_charge_current)
        else $error("off state still driving output");
    temp_stop_a: assert property (flags_in.over_temperature_shutdown [*8] |=> !ctrl_out.switching)
        else $error("switching during over temperature");
endmodule

bind boost_mode_sequencer boost_mode_sequencer_checker i_chk (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .enable_in              (enable_in),
    .pass_through_select_in (pass_through_select_in),
    .flags_in               (flags_in),
    .ctrl_out               (ctrl_out),
    .state_out              (state_out)
);
`default_nettype wire

// >>> testbench/boost_mode_sequencer_tb.sv
// self-checking testbench for the boost mode sequencer
`timescale 1ns/100ps
`default_nettype none
module boost_mode_sequencer_tb;
    logic                         clk_in = 1'b0;
    logic                         rst_in = 1'b1;
    logic                         enable_in = 1'b0;
    logic                         pass_through_select_in = 1'b0;
    boost_seq_pkg::analog_flags_s flags = '0;
    boost_seq_pkg::stage_ctrl_s   ctrl;
    boost_seq_pkg::seq_state_e    state;
    int                           err_count = 0;
    int                           samples_checked = 0;

    always #5 clk_in = ~clk_in;

    boost_mode_sequencer i_boost_mode_sequencer (
        .clk_in                 (clk_in),
        .rst_in                 (rst_in),
        .enable_in              (enable_in),
        .pass_through_select_in (pass_through_select_in),
        .flags_in               (flags),
        .ctrl_out               (ctrl),
        .state_out              (state)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_st(input boost_seq_pkg::seq_state_e s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        check(state, s);
    endtask

    task automatic restart(input logic sel = 1'b0);
        @(negedge clk_in);
        rst_in = 1'b1;
        enable_in = 1'b0;
        pass_through_select_in = 1'b0;
        flags = '0;
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        flags.uvlo_ok = 1'b1;
        pass_through_select_in = sel;
        enable_in = 1'b1;
        wait_st(boost_seq_pkg::ST_LOW_CHARGE, 20);
    endtask

    task automatic go_boost();
        restart();
        flags.out_above_in_minus_300 = 1'b1;
        wait_st(boost_seq_pkg::ST_SW_SOFT, 20);
        flags.out_at_target = 1'b1;
        wait_st(boost_seq_pkg::ST_BOOST, 20);
    endtask

    task automatic t_startup();
        restart();
        check({ctrl.low_charge_current, ctrl.high_charge_current, ctrl.switching}, 32'h4);
        flags.out_above_in_minus_300 = 1'b1;
        wait_st(boost_seq_pkg::ST_SW_SOFT, 20);
        check({ctrl.low_charge_current, ctrl.switching, ctrl.pfm, ctrl.quarter_limit}, 32'h7);
        flags.out_at_target = 1'b1;
        wait_st(boost_seq_pkg::ST_BOOST, 20);
        repeat (100) @(negedge clk_in);
        check({ctrl.switching, ctrl.pfm, ctrl.quarter_limit}, 32'h4);
        flags.light_load = 1'b1;
        repeat (10) @(negedge clk_in);
        check({ctrl.pfm, ctrl.high_pfm_target}, 32'h3);
        enable_in = 1'b0;
        wait_st(boost_seq_pkg::ST_OFF, 20);
        check(ctrl.switching, 32'h0);
    endtask

    task automatic t_stages();
        restart();
        repeat (49990) @(negedge clk_in);
        check(state, boost_seq_pkg::ST_LOW_CHARGE);
        wait_st(boost_seq_pkg::ST_HIGH_CHARGE, 30);
        check({ctrl.low_charge_current, ctrl.high_charge_current}, 32'h1);
        flags.out_above_in_minus_300 = 1'b1;
        wait_st(boost_seq_pkg::ST_SW_SOFT, 20);
        check(ctrl.high_charge_current, 32'h0);
    endtask

    task automatic t_auto();
        go_boost();
        flags.in_above_target_minus_250 = 1'b1;
        repeat (400) @(negedge clk_in);
        flags.in_above_target_minus_250 = 1'b0;
        repeat (200) @(negedge clk_in);
        check(state, boost_seq_pkg::ST_BOOST);
        flags.in_above_target_minus_250 = 1'b1;
        wait_st(boost_seq_pkg::ST_AUTO_BYPASS, 600);
        check({ctrl.auto_bypass, ctrl.output_pass_switch, ctrl.switching}, 32'h6);
        flags.in_above_target_minus_250 = 1'b0;
        flags.in_below_target_minus_350 = 1'b1;
        wait_st(boost_seq_pkg::ST_BOOST, 20);
        flags.in_below_target_minus_350 = 1'b0;
        flags.in_above_target_minus_250 = 1'b1;
        wait_st(boost_seq_pkg::ST_AUTO_BYPASS, 600);
        flags.in_above_out_plus_350 = 1'b1;
        wait_st(boost_seq_pkg::ST_FAULT, 20);
        check({ctrl.output_pass_switch, ctrl.fault}, 32'h1);
        enable_in = 1'b0;
        repeat (50) @(negedge clk_in);
        check(state, boost_seq_pkg::ST_FAULT);
    endtask

    task automatic t_forced();
        restart(1'b1);
        flags.out_above_in_minus_300 = 1'b1;
        flags.out_at_in = 1'b1;
        wait_st(boost_seq_pkg::ST_FORCED_BYPASS, 20);
        check({ctrl.forced_bypass, ctrl.switching}, 32'h2);
        flags.out_above_in_minus_300 = 1'b0;
        flags.out_at_in = 1'b0;
        flags.out_below_in_minus_450 = 1'b1;
        wait_st(boost_seq_pkg::ST_FAULT, 20);
    endtask

    task automatic t_temp_drop();
        go_boost();
        flags.over_temperature_shutdown = 1'b1;
        repeat (10) @(negedge clk_in);
        check({ctrl.switching, ctrl.pwm_gate}, 32'h0);
        flags.over_temperature_shutdown = 1'b0;
        repeat (10) @(negedge clk_in);
        check(ctrl.switching, 32'h1);
        flags.out_above_in_minus_300 = 1'b0;
        wait_st(boost_seq_pkg::ST_FAULT, 20);
    endtask

    task automatic t_lockout();
        go_boost();
        flags.uvlo_ok = 1'b0;
        wait_st(boost_seq_pkg::ST_OFF, 20);
        check(ctrl.output_pass_switch, 32'h0);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_count++;
        wrap_up();
    end

    initial begin
        t_startup();
        t_stages();
        t_auto();
        t_forced();
        t_temp_drop();
        t_lockout();
        wrap_up();
    end
endmodule
`default_nettype wire
